// ==== verilog/gpf_pkg.sv ====
// constants, layouts and types shared by the port direction and pin function block
package gpf_pkg;

  // 23 group slots of 8 bits each; slot n holds port group n
  localparam int NUM_SLOTS = 23;
  localparam int SLOT_W = 8;
  localparam int PIN_W = NUM_SLOTS * SLOT_W;
  localparam int ADDR_W = 8;
  localparam logic [7:0] NUM_SLOTS_B = 8'h17;

  // register offsets (byte addresses on the register port)
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h20;
  localparam logic [7:0] OFS_THR = 8'h40;
  localparam logic [7:0] OFS_OPMODE = 8'h60;
  localparam logic [7:0] OFS_STATUS = 8'h61;
  localparam logic [7:0] OFS_PIN = 8'h80;

  // field positions
  localparam int OPM_P04_BIT = 0;
  localparam int OPM_P22_BIT = 1;
  localparam int THR_SCHMITT_BIT = 2;
  localparam int STS_BAD_BIT = 2;
  localparam int STS_DONE_BIT = 3;
  localparam int STS_P04_BIT = 4;
  localparam int STS_P22_BIT = 5;
  localparam int STS_FP_BIT = 6;

  // values after reset, and the one threshold level code that is never stored
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [1:0] OPMODE_RST = 2'h0;
  localparam logic [1:0] THR_LEVEL_RST = 2'h0;
  localparam logic THR_SCHMITT_RST = 1'b0;
  localparam logic [1:0] THR_LEVEL_BAD = 2'h3;

  // strap sampling: cycles after reset release before the mode is latched
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'h2;

  // implemented lines per group: 97 in all, group 5 reserved
  localparam logic [PIN_W-1:0] IMPL_MASK =
    184'h33_00_00_00_00_30_00_09_00_ff_f0_ff_ff_f8_fc_ff_0e_00_fe_ff_ff_ff_ff;
  // bus-capable lines: groups 0 to 4, and group 22 bits 4 and 5
  localparam logic [PIN_W-1:0] BUS_P04_MASK = {144'h0, 40'hff_ff_ff_ff_ff};
  localparam logic [PIN_W-1:0] BUS_P22_MASK = {8'h30, 176'h0};
  // can_rx_input_only_line: group 22 bit 1
  localparam logic [PIN_W-1:0] INPUT_ONLY_MASK = {8'h02, 176'h0};

  typedef enum logic [1:0] {
    GPF_MODE_SINGLE = 2'b00,
    GPF_MODE_EXT = 2'b01,
    GPF_MODE_PROC = 2'b10,
    GPF_MODE_BAD = 2'b11
  } gpf_mode_t;

  typedef enum logic {
    GPF_CAP_SETTLE = 1'b0,
    GPF_CAP_DONE = 1'b1
  } gpf_cap_t;

endpackage: gpf_pkg

// ==== verilog/gpf_mux_if.sv ====
// signals between the port register core and the pin function selector
`timescale 1ns/100ps
interface gpf_mux_if;
  gpf_pkg::gpf_mode_t mode;
  logic [1:0] bus_en;
  logic [gpf_pkg::PIN_W-1:0] port_data;
  logic [gpf_pkg::PIN_W-1:0] port_dir;
  logic [gpf_pkg::PIN_W-1:0] xbus_out;
  logic [gpf_pkg::PIN_W-1:0] xbus_drive;
  logic [gpf_pkg::PIN_W-1:0] periph_sel;
  logic [gpf_pkg::PIN_W-1:0] periph_out;
  logic [gpf_pkg::PIN_W-1:0] periph_drive;
  logic [gpf_pkg::PIN_W-1:0] pin_out;
  logic [gpf_pkg::PIN_W-1:0] pin_oe;
  logic [gpf_pkg::PIN_W-1:0] pin_bus;

  modport ctl (
    output mode, bus_en, port_data, port_dir, xbus_out, xbus_drive, periph_sel, periph_out, periph_drive,
    input pin_out, pin_oe, pin_bus
  );
  modport mux (
    input mode, bus_en, port_data, port_dir, xbus_out, xbus_drive, periph_sel, periph_out, periph_drive,
    output pin_out, pin_oe, pin_bus
  );
endinterface: gpf_mux_if

// ==== verilog/gpf_pin_mux.sv ====
// per-line function selection: port, peripheral or external bus signal
`timescale 1ns/100ps
module gpf_pin_mux (
  // selection inputs and pin results
  gpf_mux_if.mux m
);

  logic p04_on;
  logic p22_on;
  logic [gpf_pkg::PIN_W-1:0] bus_sel;
  logic [gpf_pkg::PIN_W-1:0] per_sel;
  logic [gpf_pkg::PIN_W-1:0] port_sel;

  always_comb begin
    // processor mode forces the bus; extended mode follows the operation mode register
    p04_on = (m.mode == gpf_pkg::GPF_MODE_PROC) ||
             ((m.mode == gpf_pkg::GPF_MODE_EXT) && m.bus_en[gpf_pkg::OPM_P04_BIT]);
    p22_on = (m.mode == gpf_pkg::GPF_MODE_PROC) ||
             ((m.mode == gpf_pkg::GPF_MODE_EXT) && m.bus_en[gpf_pkg::OPM_P22_BIT]);
    bus_sel = (gpf_pkg::BUS_P04_MASK & {gpf_pkg::PIN_W{p04_on}}) |
              (gpf_pkg::BUS_P22_MASK & {gpf_pkg::PIN_W{p22_on}});
    // peripheral choice comes from the peripheral's own registers, bus function wins over it
    per_sel = m.periph_sel & ~bus_sel;
    port_sel = ~bus_sel & ~per_sel;
    m.pin_out = gpf_pkg::IMPL_MASK &
                ((bus_sel & m.xbus_out) | (per_sel & m.periph_out) | (port_sel & m.port_data));
    // the can receive line never gets a driver, whatever its direction bit says
    m.pin_oe = gpf_pkg::IMPL_MASK & ~gpf_pkg::INPUT_ONLY_MASK &
               ((bus_sel & m.xbus_drive) | (per_sel & m.periph_drive) | (port_sel & m.port_dir));
    m.pin_bus = gpf_pkg::IMPL_MASK & bus_sel;
  end

endmodule: gpf_pin_mux

// ==== verilog/gpf_port_top.sv ====
// port direction, data, threshold and pin function select block
//
// Contract
// - 97 port lines in groups; group five reserved and reads as zero; here its threshold register keeps and reads back writes.
// - each line's direction bit alone makes it input or output; here only on lines in port function, never on can_rx_input_only_line.
// - can_rx_input_only_line is input only; its direction never enables a driver.
// - shared pin function comes from mode straps or the operation mode register.
// - peripheral function on a pin is chosen by that peripheral's own registers.
// - extended mode: bus pins start as ports, become bus when register bit set.
// - single-chip mode fixes ports, processor mode fixes bus signals, register ignored.
// - processor mode needs strap a high, strap b low, flash protect low.
// - strap a low, strap b high gives extended mode with register choice.
// - three threshold levels per port plus schmitt on or off.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module gpf_port_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // register port
  input wire logic [gpf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // operation mode straps
  input wire logic mode_strap_a,
  input wire logic mode_strap_b,
  input wire logic flash_protect_input,
  // pins
  input wire logic [gpf_pkg::PIN_W-1:0] pin_in,
  output logic [gpf_pkg::PIN_W-1:0] pin_out,
  output logic [gpf_pkg::PIN_W-1:0] pin_oe_n,
  // external bus controller and peripherals
  input wire logic [gpf_pkg::PIN_W-1:0] xbus_out,
  input wire logic [gpf_pkg::PIN_W-1:0] xbus_drive,
  input wire logic [gpf_pkg::PIN_W-1:0] periph_sel,
  input wire logic [gpf_pkg::PIN_W-1:0] periph_out,
  input wire logic [gpf_pkg::PIN_W-1:0] periph_drive,
  // synchronised pin levels and pin status
  output logic [gpf_pkg::PIN_W-1:0] pin_sync_in,
  output logic [gpf_pkg::PIN_W-1:0] pin_is_bus,
  output logic [1:0] chip_mode,
  // input threshold controls, one set per group
  output logic [2*gpf_pkg::NUM_SLOTS-1:0] thr_level,
  output logic [gpf_pkg::NUM_SLOTS-1:0] schmitt_en
);

  localparam int W = gpf_pkg::PIN_W;
  localparam int N = gpf_pkg::NUM_SLOTS;

  gpf_mux_if mif ();

  gpf_pin_mux u_mux (
    .m(mif.mux)
  );

  // decoding shared by the write and read paths
  // offsets past the last group miss every window and read as zero
  function automatic logic slot_hit(input logic [7:0] addr, input logic [7:0] base);
    return (addr >= base) && (addr < (base + gpf_pkg::NUM_SLOTS_B));
  endfunction: slot_hit

  function automatic logic [4:0] slot_idx(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] d;
    d = addr - base;
    return d[4:0];
  endfunction: slot_idx

  // ------------------------------------------------------------------
  // synchronisers: pins and straps come from outside the clock domain
  logic [W-1:0] pin_meta_reg;
  logic [W-1:0] pin_meta_next;
  logic [W-1:0] pin_sync_reg;
  logic [W-1:0] pin_sync_next;
  logic [2:0] strap_meta_reg;
  logic [2:0] strap_meta_next;
  logic [2:0] strap_sync_reg;
  logic [2:0] strap_sync_next;

  always_comb begin
    // the first stage may be metastable, so only the second stage reads it
    pin_meta_next = pin_in;
    pin_sync_next = pin_meta_reg;
    strap_meta_next = {flash_protect_input, mode_strap_b, mode_strap_a};
    strap_sync_next = strap_meta_reg;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      strap_meta_reg <= 3'h0;
      strap_sync_reg <= 3'h0;
    end else begin
      pin_meta_reg <= pin_meta_next;
      pin_sync_reg <= pin_sync_next;
      strap_meta_reg <= strap_meta_next;
      strap_sync_reg <= strap_sync_next;
    end
  end

  // ------------------------------------------------------------------
  // mode capture: straps are static, so they are latched once after reset
  // a strap moved after capture is ignored until the next reset
  gpf_pkg::gpf_cap_t cap_reg;
  gpf_pkg::gpf_cap_t cap_next;
  logic [1:0] settle_reg;
  logic [1:0] settle_next;
  gpf_pkg::gpf_mode_t mode_reg;
  gpf_pkg::gpf_mode_t mode_next;
  logic fp_reg;
  logic fp_next;
  gpf_pkg::gpf_mode_t mode_dec;

  always_comb begin
    // straps: bit0 strap a, bit1 strap b, bit2 flash protect
    unique case (strap_sync_reg[1:0])
      2'b00: mode_dec = gpf_pkg::GPF_MODE_SINGLE;
      2'b10: mode_dec = gpf_pkg::GPF_MODE_EXT;
      // strap a high with flash protect high is not processor mode; pins stay ports
      2'b01: mode_dec = strap_sync_reg[2] ? gpf_pkg::GPF_MODE_SINGLE : gpf_pkg::GPF_MODE_PROC;
      2'b11: mode_dec = gpf_pkg::GPF_MODE_BAD;
    endcase
    cap_next = cap_reg;
    settle_next = settle_reg;
    mode_next = mode_reg;
    fp_next = fp_reg;
    unique case (cap_reg)
      gpf_pkg::GPF_CAP_SETTLE: begin
        if (settle_reg == gpf_pkg::STRAP_SETTLE_CYC) begin
          cap_next = gpf_pkg::GPF_CAP_DONE;
          mode_next = mode_dec;
          fp_next = strap_sync_reg[2];
        end else begin
          settle_next = settle_reg + 2'h1;
        end
      end
      gpf_pkg::GPF_CAP_DONE: begin
        cap_next = gpf_pkg::GPF_CAP_DONE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_reg <= gpf_pkg::GPF_CAP_SETTLE;
      settle_reg <= 2'h0;
      mode_reg <= gpf_pkg::GPF_MODE_SINGLE;
      fp_reg <= 1'b0;
    end else begin
      cap_reg <= cap_next;
      settle_reg <= settle_next;
      mode_reg <= mode_next;
      fp_reg <= fp_next;
    end
  end

  // ------------------------------------------------------------------
  // software registers
  logic [W-1:0] data_reg;
  logic [W-1:0] data_next;
  logic [W-1:0] dir_reg;
  logic [W-1:0] dir_next;
  logic [1:0] opmode_reg;
  logic [1:0] opmode_next;
  logic [2*N-1:0] level_reg;
  logic [2*N-1:0] level_next;
  logic [N-1:0] schmitt_reg;
  logic [N-1:0] schmitt_next;
  logic [4:0] wr_idx;
  logic [7:0] wr_bit;
  logic [7:0] impl_byte;

  always_comb begin
    data_next = data_reg;
    dir_next = dir_reg;
    opmode_next = opmode_reg;
    level_next = level_reg;
    schmitt_next = schmitt_reg;
    wr_idx = 5'h0;
    wr_bit = 8'h0;
    impl_byte = 8'h0;
    // unimplemented bits are masked on the way in, so they can never drive
    if (reg_wr) begin
      if (slot_hit(reg_addr, gpf_pkg::OFS_DATA)) begin
        wr_idx = slot_idx(reg_addr, gpf_pkg::OFS_DATA);
        wr_bit = {wr_idx, 3'h0};
        impl_byte = gpf_pkg::IMPL_MASK[wr_bit +: 8];
        data_next[wr_bit +: 8] = reg_wdata & impl_byte;
      end else if (slot_hit(reg_addr, gpf_pkg::OFS_DIR)) begin
        wr_idx = slot_idx(reg_addr, gpf_pkg::OFS_DIR);
        wr_bit = {wr_idx, 3'h0};
        impl_byte = gpf_pkg::IMPL_MASK[wr_bit +: 8];
        // one bit per line; the input-only line keeps its bit but the mux never obeys it
        dir_next[wr_bit +: 8] = reg_wdata & impl_byte;
      end else if (slot_hit(reg_addr, gpf_pkg::OFS_THR)) begin
        wr_idx = slot_idx(reg_addr, gpf_pkg::OFS_THR);
        // only three levels exist; the fourth code leaves the level unchanged
        if (reg_wdata[1:0] != gpf_pkg::THR_LEVEL_BAD) begin
          level_next[{wr_idx, 1'b0} +: 2] = reg_wdata[1:0];
        end
        schmitt_next[wr_idx] = reg_wdata[gpf_pkg::THR_SCHMITT_BIT];
      end else if (reg_addr == gpf_pkg::OFS_OPMODE) begin
        // the bits are kept in every mode; only extended mode lets the selector use them
        opmode_next[gpf_pkg::OPM_P04_BIT] = reg_wdata[gpf_pkg::OPM_P04_BIT];
        opmode_next[gpf_pkg::OPM_P22_BIT] = reg_wdata[gpf_pkg::OPM_P22_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_reg <= {N{gpf_pkg::DATA_RST}};
      dir_reg <= {N{gpf_pkg::DIR_RST}};
      opmode_reg <= gpf_pkg::OPMODE_RST;
      level_reg <= {N{gpf_pkg::THR_LEVEL_RST}};
      schmitt_reg <= {N{gpf_pkg::THR_SCHMITT_RST}};
    end else begin
      data_reg <= data_next;
      dir_reg <= dir_next;
      opmode_reg <= opmode_next;
      level_reg <= level_next;
      schmitt_reg <= schmitt_next;
    end
  end

  // ------------------------------------------------------------------
  // pin function selection
  // the selector is plain logic; everything it decides is registered below
  assign mif.mode = mode_reg;
  assign mif.bus_en = opmode_reg;
  assign mif.port_data = data_reg;
  assign mif.port_dir = dir_reg;
  assign mif.xbus_out = xbus_out;
  assign mif.xbus_drive = xbus_drive;
  assign mif.periph_sel = periph_sel;
  assign mif.periph_out = periph_out;
  assign mif.periph_drive = periph_drive;

  // outputs are registered, so a pin follows its cause one cycle late
  logic [W-1:0] pin_out_reg;
  logic [W-1:0] pin_out_next;
  logic [W-1:0] pin_oe_n_reg;
  logic [W-1:0] pin_oe_n_next;
  logic [W-1:0] pin_bus_reg;
  logic [W-1:0] pin_bus_next;

  always_comb begin
    pin_out_next = mif.pin_out;
    pin_oe_n_next = ~mif.pin_oe;
    pin_bus_next = mif.pin_bus;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_out_reg <= '0;
      pin_oe_n_reg <= '1;
      pin_bus_reg <= '0;
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_n_reg <= pin_oe_n_next;
      pin_bus_reg <= pin_bus_next;
    end
  end

  // ------------------------------------------------------------------
  // read path: data stands in the cycle after the strobe only
  logic [W-1:0] port_view;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [4:0] rd_idx;
  logic [7:0] rd_bit;
  logic [5:0] rd_lvl;
  logic [7:0] status_word;

  always_comb begin
    // driven lines read back their latch, the rest read the synchronised pin
    port_view = gpf_pkg::IMPL_MASK & ((mif.pin_oe & data_reg) | (~mif.pin_oe & pin_sync_reg));
  end

  always_comb begin
    // bus activity comes from the registered pins, so it matches what the board sees
    status_word = 8'h0;
    status_word[1:0] = mode_reg;
    status_word[gpf_pkg::STS_BAD_BIT] = (mode_reg == gpf_pkg::GPF_MODE_BAD);
    status_word[gpf_pkg::STS_DONE_BIT] = (cap_reg == gpf_pkg::GPF_CAP_DONE);
    status_word[gpf_pkg::STS_P04_BIT] = |(pin_bus_reg & gpf_pkg::BUS_P04_MASK);
    status_word[gpf_pkg::STS_P22_BIT] = |(pin_bus_reg & gpf_pkg::BUS_P22_MASK);
    status_word[gpf_pkg::STS_FP_BIT] = fp_reg;
  end

  always_comb begin
    // an unmapped offset reads as zero, never as stale data
    rdata_next = 8'h0;
    rd_idx = 5'h0;
    rd_bit = 8'h0;
    rd_lvl = 6'h0;
    if (reg_rd) begin
      if (slot_hit(reg_addr, gpf_pkg::OFS_DATA)) begin
        rd_idx = slot_idx(reg_addr, gpf_pkg::OFS_DATA);
        rd_bit = {rd_idx, 3'h0};
        rdata_next = port_view[rd_bit +: 8];
      end else if (slot_hit(reg_addr, gpf_pkg::OFS_DIR)) begin
        rd_idx = slot_idx(reg_addr, gpf_pkg::OFS_DIR);
        rd_bit = {rd_idx, 3'h0};
        rdata_next = dir_reg[rd_bit +: 8];
      end else if (slot_hit(reg_addr, gpf_pkg::OFS_THR)) begin
        rd_idx = slot_idx(reg_addr, gpf_pkg::OFS_THR);
        rd_lvl = {rd_idx, 1'b0};
        rdata_next = {5'h0, schmitt_reg[rd_idx], level_reg[rd_lvl +: 2]};
      end else if (slot_hit(reg_addr, gpf_pkg::OFS_PIN)) begin
        rd_idx = slot_idx(reg_addr, gpf_pkg::OFS_PIN);
        rd_bit = {rd_idx, 3'h0};
        rdata_next = gpf_pkg::IMPL_MASK[rd_bit +: 8] & pin_sync_reg[rd_bit +: 8];
      end else if (reg_addr == gpf_pkg::OFS_OPMODE) begin
        rdata_next = {6'h0, opmode_reg};
      end else if (reg_addr == gpf_pkg::OFS_STATUS) begin
        rdata_next = status_word;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 8'h0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs, all straight from flip-flops
  assign reg_rdata = rdata_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe_n = pin_oe_n_reg;
  assign pin_is_bus = pin_bus_reg;
  assign pin_sync_in = pin_sync_reg;
  assign chip_mode = mode_reg;
  assign thr_level = level_reg;
  assign schmitt_en = schmitt_reg;

endmodule: gpf_port_top

// ==== bench/gpf_port_sva.sv ====
// concurrent checks on the port block's top-level ports
`timescale 1ns/100ps
module gpf_port_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // register port
  input wire logic [gpf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins and status
  input wire logic [gpf_pkg::PIN_W-1:0] pin_in,
  input wire logic [gpf_pkg::PIN_W-1:0] pin_out,
  input wire logic [gpf_pkg::PIN_W-1:0] pin_oe_n,
  input wire logic [gpf_pkg::PIN_W-1:0] pin_sync_in,
  input wire logic [gpf_pkg::PIN_W-1:0] pin_is_bus,
  input wire logic [1:0] chip_mode,
  input wire logic [2*gpf_pkg::NUM_SLOTS-1:0] thr_level
);
  localparam logic [gpf_pkg::PIN_W-1:0] IMP = gpf_pkg::IMPL_MASK;
  localparam logic [gpf_pkg::PIN_W-1:0] BUS_ALL = (gpf_pkg::BUS_P04_MASK | gpf_pkg::BUS_P22_MASK) & IMP;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  logic lvl_bad;
  always_comb begin
    lvl_bad = 1'b0;
    for (int g = 0; g < gpf_pkg::NUM_SLOTS; g++) begin
      lvl_bad = lvl_bad | (thr_level[2*g +: 2] == gpf_pkg::THR_LEVEL_BAD);
    end
  end

  sequence s_proc_held;
    chip_mode == gpf_pkg::GPF_MODE_PROC ##1 chip_mode == gpf_pkg::GPF_MODE_PROC;
  endsequence
  sequence s_status_rd;
    reg_rd && reg_addr == gpf_pkg::OFS_STATUS ##1 1'b1;
  endsequence

  a_unimpl_idle: assert property (((~pin_oe_n | pin_out) & ~IMP) == '0)
    else $error("unimplemented line active");
  a_canrx_no_drive: assert property (pin_oe_n[177] == 1'b1)
    else $error("receive-only line driven");
  a_sync_two_edges: assert property ($past(arst_n, 3) |-> pin_sync_in == $past(pin_in, 2))
    else $error("pin sync delay wrong");
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_status_mode: assert property (s_status_rd |-> reg_rdata[1:0] == $past(chip_mode))
    else $error("status mode differs from chip mode");
  a_mode_frozen: assert property (chip_mode != gpf_pkg::GPF_MODE_SINGLE |=> $stable(chip_mode))
    else $error("mode changed after capture");
  a_port_only_bus: assert property (chip_mode inside {2'b00, 2'b11} |-> (pin_is_bus & IMP) == '0)
    else $error("bus function without bus mode");
  a_proc_all_bus: assert property (s_proc_held |-> (pin_is_bus & BUS_ALL) == BUS_ALL)
    else $error("processor mode pins not bus");
  a_thr_legal: assert property (!lvl_bad)
    else $error("threshold level code 3 seen");
endmodule: gpf_port_sva

bind gpf_port_top gpf_port_sva i_sva (.ref_clk, .arst_n, .reg_addr, .reg_rd, .reg_rdata, .pin_in, .pin_out,
  .pin_oe_n, .pin_sync_in, .pin_is_bus, .chip_mode, .thr_level);

// ==== bench/gpf_board_model.sv ====
// board model: pin levels, mode straps and flash protect level
`timescale 1ns/100ps
module gpf_board_model (
  // pins of the block
  input wire logic [gpf_pkg::PIN_W-1:0] pin_out,
  input wire logic [gpf_pkg::PIN_W-1:0] pin_oe_n,
  // board setup chosen by the bench
  input wire logic [1:0] mode_sel,
  input wire logic fp_sel,
  input wire logic [gpf_pkg::PIN_W-1:0] ext_level,
  // levels seen by the block
  output logic [gpf_pkg::PIN_W-1:0] pin_in,
  output logic mode_strap_a,
  output logic mode_strap_b,
  output logic flash_protect_input
);
  // a released line shows the board level, never the last driven value
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
  // 11 is never fitted on a real board; only set when the bench asks for it
  assign mode_strap_a = mode_sel[1];
  assign mode_strap_b = mode_sel[0];
  assign flash_protect_input = fp_sel;
endmodule: gpf_board_model

// ==== bench/gpf_port_top_test.sv ====
// self-checking bench for the port direction and pin function block
`timescale 1ns/100ps
module gpf_port_top_test;
  localparam int W = gpf_pkg::PIN_W;
  localparam logic [W-1:0] IMP = gpf_pkg::IMPL_MASK;
  localparam logic [W-1:0] B04 = gpf_pkg::BUS_P04_MASK & IMP;
  localparam logic [W-1:0] B22 = gpf_pkg::BUS_P22_MASK & IMP;
  logic ref_clk;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] mode_sel = 2'b00;
  logic fp_sel = 1'b0;
  logic [W-1:0] ext_level = {23{8'h96}};
  logic [W-1:0] xbus_out = '0;
  logic [W-1:0] xbus_drive = '0;
  logic [W-1:0] periph_sel = '0;
  logic [W-1:0] periph_out = '0;
  logic [W-1:0] periph_drive = '0;
  logic [7:0] reg_rdata, rv;
  logic mode_strap_a, mode_strap_b, flash_protect_input;
  logic [W-1:0] pin_in, pin_out, pin_oe_n, pin_sync_in, pin_is_bus;
  logic [1:0] chip_mode;
  logic [2*gpf_pkg::NUM_SLOTS-1:0] thr_level;
  logic [gpf_pkg::NUM_SLOTS-1:0] schmitt_en;
  int n_fail = 0;
  int checks_done = 0;

  gpf_port_top i_dut (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mode_strap_a,
    .mode_strap_b, .flash_protect_input, .pin_in, .pin_out, .pin_oe_n, .xbus_out, .xbus_drive, .periph_sel,
    .periph_out, .periph_drive, .pin_sync_in, .pin_is_bus, .chip_mode, .thr_level, .schmitt_en);
  gpf_board_model i_board (.pin_out, .pin_oe_n, .mode_sel, .fp_sel, .ext_level, .pin_in, .mode_strap_a,
    .mode_strap_b, .flash_protect_input);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop;
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask: report_and_stop

  task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s", $time, what);
    end
  endtask: chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask: wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask: rd

  // pin outputs follow a write two edges after its strobe cycle
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask: settle

  // straps are sampled only once after release, so each mode needs its own reset
  task automatic do_reset(input logic [1:0] m, input logic f);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    mode_sel <= m;
    fp_sel <= f;
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
  endtask: do_reset

  task automatic t_single;
    do_reset(2'b00, 1'b0);
    chk(chip_mode, 2'b00, "single mode");
    wr(gpf_pkg::OFS_OPMODE, 8'h03);
    wr(gpf_pkg::OFS_DIR, 8'hff);
    wr(gpf_pkg::OFS_DATA, 8'h5a);
    wr(gpf_pkg::OFS_DIR + 8'h01, 8'h0f);
    wr(gpf_pkg::OFS_DIR + 8'h04, 8'hff);
    wr(gpf_pkg::OFS_DIR + 8'h05, 8'hff);
    wr(gpf_pkg::OFS_DIR + 8'h16, 8'hff);
    settle();
    chk(pin_is_bus, '0, "bus in single mode");
    chk(pin_oe_n[15:0], 16'hf000, "dir g0 g1");
    chk(pin_out[7:0], 8'h5a, "data g0");
    chk(pin_oe_n[47:32], 16'hff01, "dir g4 g5");
    chk(pin_oe_n[183:176], 8'hce, "receive line");
    rd(gpf_pkg::OFS_DIR + 8'h05, rv);
    chk(rv, 8'h00, "reserved group");
    rd(8'h70, rv);
    chk(rv, 8'h00, "unmapped read");
    rd(gpf_pkg::OFS_DATA + 8'h01, rv);
    chk(rv, 8'h90, "mixed data read");
    rd(gpf_pkg::OFS_PIN + 8'h02, rv);
    chk(rv, 8'h96, "pin g2");
    @(posedge ref_clk);
    periph_sel[12] <= 1'b1;
    periph_out[12] <= 1'b1;
    periph_drive[12] <= 1'b1;
    ext_level <= {23{8'h69}};
    settle();
    chk({pin_oe_n[15:8], pin_out[15:8]}, 16'he010, "peripheral pin");
    rd(gpf_pkg::OFS_PIN + 8'h02, rv);
    chk(rv, 8'h69, "pin g2 changed");
  endtask: t_single

  task automatic t_thresh;
    for (int lv = 2; lv >= 0; lv--) begin
      wr(gpf_pkg::OFS_THR + 8'h03, {5'h00, lv[0], lv[1:0]});
      settle();
      chk({schmitt_en[3], thr_level[7:6]}, {lv[0], lv[1:0]}, "threshold");
    end
    wr(gpf_pkg::OFS_THR + 8'h03, 8'h07);
    settle();
    chk({schmitt_en[3], thr_level[7:6]}, 3'b100, "level code 3");
  endtask: t_thresh

  task automatic t_ext;
    do_reset(2'b01, 1'b0);
    chk(chip_mode, 2'b01, "ext mode");
    chk(pin_is_bus, '0, "ext default port");
    @(posedge ref_clk);
    xbus_drive[7:0] <= 8'hff;
    xbus_out[7:0] <= 8'hc3;
    wr(gpf_pkg::OFS_OPMODE, 8'h01);
    settle();
    chk(pin_is_bus & IMP, B04, "ext g0-4 bus");
    chk({pin_oe_n[7:0], pin_out[7:0]}, 16'h00c3, "bus drive");
    wr(gpf_pkg::OFS_OPMODE, 8'h03);
    settle();
    chk(pin_is_bus & IMP, B04 | B22, "ext all bus");
    rd(gpf_pkg::OFS_STATUS, rv);
    chk(rv[5:0], 6'h39, "ext status");
  endtask: t_ext

  task automatic t_proc;
    do_reset(2'b10, 1'b0);
    chk(chip_mode, 2'b10, "proc mode");
    wr(gpf_pkg::OFS_OPMODE, 8'h00);
    settle();
    chk(pin_is_bus & IMP, B04 | B22, "proc bus");
    do_reset(2'b10, 1'b1);
    chk(chip_mode, 2'b00, "proc with protect");
    rd(gpf_pkg::OFS_STATUS, rv);
    chk(rv, 8'h48, "protect status");
    do_reset(2'b11, 1'b0);
    chk(chip_mode, 2'b11, "both straps");
    rd(gpf_pkg::OFS_STATUS, rv);
    chk(rv[2], 1'b1, "bad strap flag");
    chk(pin_is_bus & IMP, '0, "bad mode ports");
  endtask: t_proc

  initial begin
    t_single();
    t_thresh();
    t_ext();
    t_proc();
    report_and_stop();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    report_and_stop();
  end
endmodule: gpf_port_top_test
